// [common/qpc_defines.svh]
// Constants for the quad potentiometer control and configuration block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef QPC_DEFINES_SVH
`define QPC_DEFINES_SVH
// Control register fields and reset value
`define QPC_CTRL_WIDTH 4
`define QPC_CTRL_WP_BIT 0
`define QPC_CTRL_PROG_BIT 1
`define QPC_CTRL_GAIN_BIT 2
`define QPC_CTRL_BURST_BIT 3
`define QPC_CTRL_RESET 4'h3
// Command codes (upper nibble of the command byte)
`define QPC_CMD_NOP 4'h0
`define QPC_CMD_WR_INPUT 4'h1
`define QPC_CMD_WR_WIPER 4'h2
`define QPC_CMD_READ 4'h3
`define QPC_CMD_COPY_IN 4'h6
`define QPC_CMD_NV_COPY 4'h7
`define QPC_CMD_NV_WRITE 4'h8
`define QPC_CMD_SCALE 4'h9
`define QPC_CMD_SW_RESET 4'hB
`define QPC_CMD_CTRL 4'hD
// Read-back selectors
`define QPC_RD_INPUT 2'h0
`define QPC_RD_NV 2'h1
`define QPC_RD_CTRL 2'h2
`define QPC_RD_WIPER 2'h3
// Address fields
`define QPC_ADDR_ALL_BIT 3
`define QPC_ADDR_AHALF_BIT 2
`define QPC_NUM_CH 4
`endif

// [common/qpc_pkg.sv]
// Types for the quad potentiometer control and configuration block.
// Assumes the defines header is compiled alongside.
package qpc_pkg;
    // Scale override of one channel
    typedef enum logic [1:0] {
        QPC_SCALE_NONE,
        QPC_SCALE_TOP,
        QPC_SCALE_BOTTOM
    } qpc_scale_t;
endpackage : qpc_pkg

// [hdl/qpc_tap_decode.sv]
// Tap decode for one channel: turns codes into wiper-to-A and wiper-to-B settings.
// Assumes codes are already limited to the variant width by the caller.
`timescale 1ns/1ps
`include "qpc_defines.svh"
module qpc_tap_decode #(
    parameter int CODE_W = 8
) (
    input wire logic [CODE_W-1:0] wb_code,
    input wire logic [CODE_W-1:0] aw_code,
    input wire logic gain_mode,
    input wire qpc_pkg::qpc_scale_t scale,
    output logic [CODE_W:0] wiper_to_b_setting,
    output logic [CODE_W:0] wiper_to_a_setting
);
    localparam logic [CODE_W:0] FULL = {1'b1, {CODE_W{1'b0}}};

    // One extra bit lets the full-scale step count be expressed
    always_comb begin
        wiper_to_b_setting = {1'b0, wb_code};
        if (gain_mode) begin
            wiper_to_a_setting = {1'b0, aw_code};
        end else begin
            wiper_to_a_setting = FULL - {1'b0, wb_code};
        end
        case (scale)
            qpc_pkg::QPC_SCALE_TOP: begin
                wiper_to_b_setting = FULL;
                wiper_to_a_setting = '0;
            end
            qpc_pkg::QPC_SCALE_BOTTOM: begin
                wiper_to_b_setting = '0;
                wiper_to_a_setting = FULL;
            end
            default: begin
            end
        endcase
    end
endmodule : qpc_tap_decode

// [hdl/qpc_core.sv]
// Control, configuration and wiper storage of a quad nonvolatile potentiometer.
// Assumes a framer on the same clock hands over whole 16-bit words as one-cycle strobes.
`timescale 1ns/1ps
`include "qpc_defines.svh"
module qpc_core #(
    parameter int CODE_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic frame_end,
    input wire logic restart_seen,
    output logic [7:0] read_data,
    output logic read_valid,
    output logic [`QPC_CTRL_WIDTH-1:0] ctrl_bits,
    output logic burst_active,
    output logic nv_busy,
    output logic [(CODE_W+1)*`QPC_NUM_CH-1:0] wiper_to_b_setting,
    output logic [(CODE_W+1)*`QPC_NUM_CH-1:0] wiper_to_a_setting
);
    localparam int NCH = `QPC_NUM_CH;

    // Only the 128- and 256-position variants have a defined code range
    if (CODE_W != 7 && CODE_W != 8) begin : g_bad_code_w
        $error("CODE_W must be 7 or 8");
    end

    // Limit a data byte to the variant code range
    function automatic logic [CODE_W-1:0] clip_code(input logic [7:0] b);
        clip_code = b[CODE_W-1:0];
    endfunction : clip_code

    // Channel hit for an address nibble; a_half chooses which half is addressed
    function automatic logic ch_hit(input logic [3:0] a, input int ch, input logic a_half);
        ch_hit = a[`QPC_ADDR_ALL_BIT] |
                 ((a[1:0] == 2'(ch)) && (a[`QPC_ADDR_AHALF_BIT] == a_half));
    endfunction : ch_hit

    logic [`QPC_CTRL_WIDTH-1:0] ctrl_q, ctrl_d;
    logic [CODE_W-1:0] in_b_q [NCH], in_b_d [NCH];
    logic [CODE_W-1:0] in_a_q [NCH], in_a_d [NCH];
    logic [CODE_W-1:0] wb_q [NCH], wb_d [NCH];
    logic [CODE_W-1:0] wa_q [NCH], wa_d [NCH];
    logic [CODE_W-1:0] nv_q [NCH], nv_d [NCH];
    qpc_pkg::qpc_scale_t scale_q [NCH], scale_d [NCH];
    logic burst_q, burst_d;
    logic [7:0] rd_q, rd_d;
    logic rdv_q, rdv_d;
    logic [3:0] cmd, adr;
    logic [7:0] dat;
    logic gain, wr_ok, nv_ok;

    assign cmd = cmd_word[15:12];
    assign adr = cmd_word[11:8];
    assign dat = cmd_word[7:0];
    assign gain = ctrl_q[`QPC_CTRL_GAIN_BIT];
    assign wr_ok = ctrl_q[`QPC_CTRL_WP_BIT];
    assign nv_ok = ctrl_q[`QPC_CTRL_PROG_BIT];

    // Next-state of all command-driven storage
    always_comb begin
        ctrl_d = ctrl_q;
        in_b_d = in_b_q;
        in_a_d = in_a_q;
        wb_d = wb_q;
        wa_d = wa_q;
        nv_d = nv_q;
        scale_d = scale_q;
        burst_d = burst_q;
        rd_d = rd_q;
        rdv_d = 1'b0;
        // Burst persists across stop/restart only while enabled
        if ((frame_end || restart_seen) && !ctrl_q[`QPC_CTRL_BURST_BIT]) begin
            burst_d = 1'b0;
        end
        if (cmd_valid) begin
            if (ctrl_q[`QPC_CTRL_BURST_BIT]) begin
                burst_d = 1'b1;
            end
            case (cmd)
                `QPC_CMD_CTRL: begin
                    ctrl_d = dat[`QPC_CTRL_WIDTH-1:0];
                end
                `QPC_CMD_WR_INPUT, `QPC_CMD_WR_WIPER: begin
                    for (int c = 0; c < NCH; c++) begin
                        // All-channel address ignores the A-half bit in either mode
                        if (ch_hit(adr, c, 1'b0) &&
                            (adr[`QPC_ADDR_ALL_BIT] || gain || !adr[`QPC_ADDR_AHALF_BIT])) begin
                            in_b_d[c] = clip_code(dat);
                            if (cmd == `QPC_CMD_WR_WIPER && wr_ok) begin
                                wb_d[c] = clip_code(dat);
                            end
                        end
                        // Wiper-to-A half only exists in gain mode
                        if (gain && ch_hit(adr, c, 1'b1)) begin
                            in_a_d[c] = clip_code(dat);
                            if (cmd == `QPC_CMD_WR_WIPER && wr_ok) begin
                                wa_d[c] = clip_code(dat);
                            end
                        end
                    end
                end
                `QPC_CMD_COPY_IN: begin
                    for (int c = 0; c < NCH; c++) begin
                        if (wr_ok && ch_hit(adr, c, 1'b0)) begin
                            wb_d[c] = in_b_q[c];
                            wa_d[c] = in_a_q[c];
                        end
                    end
                end
                `QPC_CMD_NV_COPY: begin
                    for (int c = 0; c < NCH; c++) begin
                        if (adr[1:0] == 2'(c)) begin
                            if (dat[0] && nv_ok) begin
                                nv_d[c] = wb_q[c];
                            end else if (!dat[0]) begin
                                wb_d[c] = nv_q[c];
                            end
                        end
                    end
                end
                `QPC_CMD_NV_WRITE: begin
                    for (int c = 0; c < NCH; c++) begin
                        if (nv_ok && adr[1:0] == 2'(c)) begin
                            nv_d[c] = clip_code(dat);
                        end
                    end
                end
                `QPC_CMD_SCALE: begin
                    for (int c = 0; c < NCH; c++) begin
                        if (ch_hit(adr, c, 1'b0) || ch_hit(adr, c, 1'b1)) begin
                            if (!dat[0]) begin
                                scale_d[c] = qpc_pkg::QPC_SCALE_NONE;
                            end else if (dat[7]) begin
                                scale_d[c] = qpc_pkg::QPC_SCALE_TOP;
                            end else begin
                                scale_d[c] = qpc_pkg::QPC_SCALE_BOTTOM;
                            end
                        end
                    end
                end
                `QPC_CMD_SW_RESET: begin
                    // Reload wipers from nonvolatile store, as at power-on
                    for (int c = 0; c < NCH; c++) begin
                        wb_d[c] = nv_q[c];
                        wa_d[c] = nv_q[c];
                        in_b_d[c] = nv_q[c];
                        in_a_d[c] = nv_q[c];
                        scale_d[c] = qpc_pkg::QPC_SCALE_NONE;
                    end
                end
                `QPC_CMD_READ: begin
                    rdv_d = 1'b1;
                    case (dat[1:0])
                        `QPC_RD_INPUT: rd_d = 8'(adr[2] ? in_a_q[adr[1:0]] : in_b_q[adr[1:0]]);
                        `QPC_RD_NV: rd_d = 8'(nv_q[adr[1:0]]);
                        `QPC_RD_CTRL: rd_d = {4'h0, ctrl_q};
                        default: rd_d = 8'(adr[2] ? wa_q[adr[1:0]] : wb_q[adr[1:0]]);
                    endcase
                end
                default: begin
                end
            endcase
        end
    end

    // Nonvolatile store resets to zero here; the restore path is a software reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `QPC_CTRL_RESET;
            burst_q <= 1'b0;
            rd_q <= 8'h00;
            rdv_q <= 1'b0;
            for (int c = 0; c < NCH; c++) begin
                in_b_q[c] <= '0;
                in_a_q[c] <= '0;
                wb_q[c] <= '0;
                wa_q[c] <= '0;
                nv_q[c] <= '0;
                scale_q[c] <= qpc_pkg::QPC_SCALE_NONE;
            end
        end else begin
            ctrl_q <= ctrl_d;
            burst_q <= burst_d;
            rd_q <= rd_d;
            rdv_q <= rdv_d;
            in_b_q <= in_b_d;
            in_a_q <= in_a_d;
            wb_q <= wb_d;
            wa_q <= wa_d;
            nv_q <= nv_d;
            scale_q <= scale_d;
        end
    end

    assign ctrl_bits = ctrl_q;
    assign burst_active = burst_q;
    assign read_data = rd_q;
    assign read_valid = rdv_q;
    assign nv_busy = 1'b0;

    // Per-channel tap decode
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        qpc_tap_decode #(
            .CODE_W(CODE_W)
        ) u_dec (
            .wb_code(wb_q[g]),
            .aw_code(wa_q[g]),
            .gain_mode(gain),
            .scale(scale_q[g]),
            .wiper_to_b_setting(wiper_to_b_setting[g*(CODE_W+1) +: CODE_W+1]),
            .wiper_to_a_setting(wiper_to_a_setting[g*(CODE_W+1) +: CODE_W+1])
        );
    end
endmodule : qpc_core

// [sim/qpc_core_assertions.sv]
// Concurrent checks on the control core ports.
// Assumes it is bound onto qpc_core and shares its single clock.
`timescale 1ns/1ps
`include "qpc_defines.svh"
module qpc_core_assertions #(
    parameter int CODE_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic frame_end,
    input wire logic restart_seen,
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    input wire logic [`QPC_CTRL_WIDTH-1:0] ctrl_bits,
    input wire logic burst_active,
    input wire logic [4*(CODE_W+1)-1:0] wiper_to_b_setting,
    input wire logic [4*(CODE_W+1)-1:0] wiper_to_a_setting
);
    localparam int W = CODE_W + 1;
    logic [3:0] op;
    logic sum_ok;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Opcode of the word presented, NOP when idle
    assign op = cmd_valid ? cmd_word[15:12] : 4'h0;
    // Both halves add up to full scale on every channel, scale positions included
    always_comb begin
        sum_ok = 1'b1;
        for (int c = 0; c < 4; c++) begin
            if (int'(wiper_to_a_setting[c*W+:W]) + int'(wiper_to_b_setting[c*W+:W])
                != (1 << CODE_W)) begin
                sum_ok = 1'b0;
            end
        end
    end
    sequence s_ctrl_cmd;
        op == 4'hD;
    endsequence
    // Stop or restart while burst is kept enabled
    sequence s_stop_burst;
        burst_active && ctrl_bits[3] && (frame_end || restart_seen) && !cmd_valid;
    endsequence
    chk_ctrl_load: assert property (s_ctrl_cmd |=> ctrl_bits == $past(cmd_word[3:0]))
        else $error("control bits not loaded together");
    chk_ctrl_hold: assert property (!(op inside {4'hD, 4'hB}) |=> $stable(ctrl_bits))
        else $error("control bits moved without a control command");
    chk_ctrl_read: assert property (op == 4'h3 && cmd_word[1:0] == 2'h2
        |=> read_valid && read_data == {4'h0, $past(ctrl_bits)})
        else $error("control read-back wrong");
    chk_wp_freeze: assert property (op == 4'h2 && !ctrl_bits[0]
        |=> $stable(wiper_to_b_setting) && $stable(wiper_to_a_setting))
        else $error("wiper moved while protected");
    chk_wiper_load: assert property (op == 4'h2 && cmd_word[11:8] == 4'h0 && ctrl_bits[0]
        |=> wiper_to_b_setting[W-1:0] == W'($past(cmd_word[CODE_W-1:0])))
        else $error("wiper code not applied");
    chk_pot_comp: assert property (!ctrl_bits[2] |-> sum_ok)
        else $error("wiper-to-A not complement in potentiometer mode");
    chk_gain_own: assert property (op == 4'h2 && cmd_word[11:8] == 4'h4
        && ctrl_bits[2:0] == 3'h7
        |=> wiper_to_a_setting[W-1:0] == W'($past(cmd_word[CODE_W-1:0]))
        && $stable(wiper_to_b_setting[W-1:0]))
        else $error("gain mode A half not loaded on its own");
    chk_top_scale: assert property (op == 4'h9 && cmd_word[11:0] == 12'h181
        |=> wiper_to_b_setting[2*W-1:W] == W'(1 << CODE_W) && wiper_to_a_setting[2*W-1:W] == '0)
        else $error("top scale position wrong");
    chk_burst_keep: assert property (s_stop_burst |=> burst_active)
        else $error("burst cancelled while enabled");
    chk_burst_drop: assert property (burst_active && !ctrl_bits[3] && frame_end && !cmd_valid
        |=> !burst_active)
        else $error("burst kept after stop while disabled");
endmodule : qpc_core_assertions

// [sim/qpc_host_model.sv]
// Host controller model handing whole command words and bus events to the core.
// Assumes the bench calls its tasks; it drives on the falling edge of core_clk.
`timescale 1ns/1ps
module qpc_host_model (
    input wire logic core_clk,
    output logic cmd_valid,
    output logic [15:0] cmd_word,
    output logic frame_end,
    output logic restart_seen
);
    // Idle bus at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_word = 16'h0000;
        frame_end = 1'b0;
        restart_seen = 1'b0;
    end
    // One whole word per command, control data in the low nibble
    task automatic issue(input logic [15:0] w);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_word = w;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        cmd_word = ~w; // Stale word is scrambled so a late sample shows up
    endtask : issue
    // Stop when stop is set, repeated start otherwise
    task automatic bus_event(input logic stop);
        @(negedge core_clk);
        frame_end = stop;
        restart_seen = !stop;
        @(negedge core_clk);
        frame_end = 1'b0;
        restart_seen = 1'b0;
    endtask : bus_event
endmodule : qpc_host_model

// [sim/quad_pot_control_config_tb_top.sv]
// Self-checking bench for the control core, 256-position variant.
// Assumes the host model drives all command inputs.
`timescale 1ns/1ps
module quad_pot_control_config_tb_top;
    localparam int W = 9;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid, frame_end, restart_seen, read_valid, burst_active, nv_busy;
    logic [15:0] cmd_word;
    logic [7:0] read_data;
    logic [3:0] ctrl_bits;
    logic [4*W-1:0] wb, wa;
    int num_errors = 0;
    int samples_checked = 0;
    always #10 core_clk = ~core_clk;
    qpc_host_model qpc_host_model_i (.core_clk, .cmd_valid, .cmd_word, .frame_end, .restart_seen);
    qpc_core #(.CODE_W(8)) qpc_core_i (.core_clk, .rst_b, .cmd_valid, .cmd_word, .frame_end,
        .restart_seen, .read_data, .read_valid, .ctrl_bits, .burst_active, .nv_busy,
        .wiper_to_b_setting(wb), .wiper_to_a_setting(wa));
    function automatic logic [9:0] b_of(input int c);
        return {1'b0, wb[c*W+:W]};
    endfunction : b_of
    function automatic logic [9:0] a_of(input int c);
        return {1'b0, wa[c*W+:W]};
    endfunction : a_of
    // Compare and count; unknowns never match
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic op(input logic [15:0] w);
        qpc_host_model_i.issue(w);
    endtask : op
    task automatic wrap_up();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic t_reset();
        check({6'h00, ctrl_bits}, 10'h003); // Defaults
        check({9'h000, nv_busy}, 10'h000); // Never busy
        for (int c = 0; c < 4; c++) check(a_of(c) - b_of(c), 10'h100); // Full A
    endtask : t_reset
    task automatic t_write();
        op(16'h21FF);
        check(b_of(1), 10'h0FF); // Top code
        check(a_of(1), 10'h001); // Complement
        op(16'h2840);
        for (int c = 0; c < 4; c++) check(b_of(c), 10'h040); // All channels
    endtask : t_write
    task automatic t_protect();
        op(16'hD002);
        check({6'h00, ctrl_bits}, 10'h002); // Low nibble loaded
        op(16'h2011);
        check(b_of(0), 10'h040); // Frozen
        op(16'h3000);
        check({read_valid, 1'b0, read_data}, 10'h211); // Input still loads
        op(16'hD003);
    endtask : t_protect
    task automatic t_nv();
        op(16'hD001);
        op(16'h8222);
        op(16'h3201);
        check({2'h0, read_data}, 10'h000); // Program blocked
        op(16'hD003);
        op(16'h8222);
        op(16'h3201);
        check({2'h0, read_data}, 10'h022); // Program allowed
    endtask : t_nv
    task automatic t_gain();
        op(16'hD007);
        op(16'h2430);
        check(a_of(0), 10'h030); // Own A code
        check(b_of(0), 10'h040); // B half kept
        op(16'hD003);
        check(a_of(0), 10'h0C0); // Back to complement
        op(16'h2455);
        check(b_of(0), 10'h040); // A half refused here
        op(16'h3403);
        check({read_valid, 1'b0, read_data}, 10'h230); // A code kept
    endtask : t_gain
    task automatic t_scale();
        op(16'h9181);
        check(a_of(1), 10'h000); // Top scale A
        check(b_of(1), 10'h100); // Top scale B
        op(16'h9180);
        check(b_of(1), 10'h040); // Left top scale
        op(16'h9101);
        check(a_of(1), 10'h100); // Bottom scale
        op(16'h9100);
    endtask : t_scale
    // Read-back, copies between stores and software reset
    task automatic t_copy();
        op(16'h3002);
        check({read_valid, 1'b0, read_data}, 10'h203); // Control read
        op(16'h6000);
        check(b_of(0), 10'h011); // Input copied
        op(16'h2055);
        check(b_of(0), 10'h055); // Channel 0 load
        op(16'h7201);
        op(16'h3201);
        check({read_valid, 1'b0, read_data}, 10'h240); // Wiper stored
        op(16'h22AA);
        op(16'h7200);
        check(b_of(2), 10'h040); // Stored value restored
        op(16'hB000);
        check(b_of(0), 10'h000); // Soft reset reload
        op(16'h3203);
        check({read_valid, 1'b0, read_data}, 10'h240); // Wiper read
    endtask : t_copy
    task automatic t_burst();
        op(16'hD00B);
        op(16'h1000);
        qpc_host_model_i.bus_event(1'b1);
        qpc_host_model_i.bus_event(1'b0);
        check({9'h000, burst_active}, 10'h001); // Survives stop and restart
        op(16'hD003);
        qpc_host_model_i.bus_event(1'b1);
        check({9'h000, burst_active}, 10'h000); // Stop cancels when off
    endtask : t_burst
    // Watchdog so a stuck run still reports
    initial begin
        repeat (100000) @(posedge core_clk);
        num_errors++;
        wrap_up();
    end
    // Reset held 8 cycles, then scenarios in order
    initial begin
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        rst_b = 1'b1;
        t_reset();
        t_write();
        t_protect();
        t_nv();
        t_gain();
        t_scale();
        t_copy();
        t_burst();
        wrap_up();
    end
endmodule : quad_pot_control_config_tb_top
bind qpc_core qpc_core_assertions #(.CODE_W(CODE_W)) qpc_core_assertions_i (.core_clk, .rst_b,
    .cmd_valid, .cmd_word, .frame_end, .restart_seen, .read_data, .read_valid, .ctrl_bits,
    .burst_active, .wiper_to_b_setting, .wiper_to_a_setting);
